// *** add_and_scaled_address_adder.sv ***
// integer, scaled address and double-precision add datapath behind an apb slave
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
// Function
// - with condition true write src1+src2 on logic/shift units, else do nothing
// - shift-unit add opfields 0x07 register and 0x06 signed 5-bit constant
// - data-unit add opfields 0x10 register and 0x12 unsigned 5-bit constant
// - integer and address adds finish in one cycle, zero delay slots
// - byte address add, unshifted offset, opfields 0x30 and 0x32
// - linear by default, circular only for base A4-A7/B4-B7 per mode register
// - halfword address add shifts offset by 1, opfields 0x34 and 0x36
// - word address add shifts offset by 2, opfields 0x38 and 0x3A
// - double add on logic unit 0x18, shift unit 0x72 on enhanced core
// - double add uses adder config register, never the auxiliary one
// - any rounding sets the inexact flag
// - NaN source gives default NaN; signalling NaN also sets invalid
// - plus infinity plus minus infinity gives default NaN and invalid
// - one infinity otherwise returns that infinity and sets infinity flag
// - overflow sets inexact, overflow; infinity or largest finite per mode
// - underflow sets inexact, underflow; signed zero or smallest normal
// - low halves read in E1, high in E2, six delay slots
// - equal magnitudes of opposite sign give +0, -0 when rounding down
// - denormal source acts as signed zero, sets its flag, inexact mostly
module add_and_scaled_address_adder
	import adder_pkg::*;
#(
	parameter bit ENHANCED_CORE = 1'b1
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);
	state_s st_reg, st_next;
	logic        wr, wr_cmd, int_go, dp_go, dp_wr, is_dp, int_ok, addr_op, clr_inexact_flag;
	logic [31:0] int_res, off_sc, base;
	logic [4:0]  cst;
	logic [1:0]  scale;
	fp_res_s     fr;

	// double add; denormals flushed to zero, guard/round/sticky kept through alignment
	function automatic fp_res_s fp_add(input logic [63:0] a, input logic [63:0] b, input logic [1:0] rm);
		fp_res_s            r;
		logic               an, bn, asn, bsn, ai, bi, za, zb, sg, sw, up;
		logic [10:0]        ea, eb;
		logic [55:0]        mb, ms, msk;
		logic [56:0]        sm;
		logic [53:0]        mr;
		logic [11:0]        d;
		logic signed [12:0] e;
		int                 lz;
		r   = '0;
		ea  = a[62:52];
		eb  = b[62:52];
		an  = (&ea) && (|a[51:0]);
		bn  = (&eb) && (|b[51:0]);
		asn = an && !a[51];
		bsn = bn && !b[51];
		ai  = (&ea) && !(|a[51:0]);
		bi  = (&eb) && !(|b[51:0]);
		za  = (ea == 11'h000);
		zb  = (eb == 11'h000);
		r.fl.den1 = za && (|a[51:0]);
		r.fl.den2 = zb && (|b[51:0]);
		if (an || bn) begin
			r.val      = DEFAULT_NAN_RESULT;
			r.fl.invalid_flag = asn || bsn;
		end else if (ai && bi && (a[63] != b[63])) begin
			r.val      = DEFAULT_NAN_RESULT;
			r.fl.invalid_flag = 1'b1;
		end else if (ai || bi) begin
			r.val     = ai ? a : b;
			r.fl.infinity_result_flag = 1'b1;
		end else begin
			r.fl.inexact_flag = r.fl.den1 || r.fl.den2;
			sw = {eb, b[51:0] & {52{!zb}}} > {ea, a[51:0] & {52{!za}}};
			mb = sw ? {!zb, b[51:0] & {52{!zb}}, 3'h0} : {!za, a[51:0] & {52{!za}}, 3'h0};
			ms = sw ? {!za, a[51:0] & {52{!za}}, 3'h0} : {!zb, b[51:0] & {52{!zb}}, 3'h0};
			sg = sw ? b[63] : a[63];
			e  = sw ? 13'(eb) : 13'(ea);
			d  = sw ? {1'b0, eb - ea} : {1'b0, ea - eb};
			if (d >= 12'd56) begin
				ms = {55'h0, |ms};
			end else begin
				msk = (56'h1 << d) - 56'h1;
				ms  = (ms >> d) | {55'h0, |(ms & msk)};
			end
			sm = (a[63] ^ b[63]) ? ({1'b0, mb} - {1'b0, ms}) : ({1'b0, mb} + {1'b0, ms});
			if (sm == 57'h0) begin
				// same-sign zeros keep sign, cancellation is +0 except rounding down
				r.val = {(a[63] == b[63]) ? a[63] : (rm == RM_NEG_INF), 63'h0};
			end else begin
				if (sm[56]) begin
					sm = {1'b0, sm[56:2], sm[1] | sm[0]};
					e  = e + 13'sd1;
				end else begin
					lz = 0;
					for (int i = 0; i < 56; i++) begin
						if (sm[i]) begin
							lz = 55 - i;
						end
					end
					sm = sm << lz;
					e  = e - 13'(lz);
				end
				r.fl.inexact_flag = r.fl.inexact_flag || (|sm[2:0]);
				unique case (rm)
					RM_NEAREST: up = sm[2] && (sm[1] || sm[0] || sm[3]);
					RM_ZERO:    up = 1'b0;
					RM_POS_INF: up = !sg && (|sm[2:0]);
					RM_NEG_INF: up = sg && (|sm[2:0]);
				endcase
				mr = {1'b0, sm[55:3]} + {53'h0, up};
				if (mr[53]) begin
					mr = mr >> 1;
					e  = e + 13'sd1;
				end
				if (e >= 13'sd2047) begin
					r.fl.ovf  = 1'b1;
					r.fl.inexact_flag = 1'b1;
					r.val = {sg, ((rm == RM_NEAREST) || (rm == RM_POS_INF && !sg) || (rm == RM_NEG_INF && sg)) ?
						INF_MAG : LARGEST_FINITE_VALUE};
				end else if (e <= 13'sd0) begin
					r.fl.unf  = 1'b1;
					r.fl.inexact_flag = 1'b1;
					r.val = {sg, ((rm == RM_POS_INF && !sg) || (rm == RM_NEG_INF && sg)) ?
						SMALLEST_NORMAL_VALUE : 63'h0};
				end else begin
					r.val = {sg, e[10:0], mr[51:0]};
				end
			end
		end
		return r;
	endfunction

	// scaled address add; circular block is 2^(N+1) bytes, only A4-A7/B4-B7 qualify
	function automatic logic [31:0] addr_add(input logic [31:0] bse, input logic [31:0] off,
		input logic [4:0] num, input logic side, input logic [31:0] addressing_mode_register);
		logic [1:0]  md;
		logic [4:0]  bk;
		logic [32:0] msk;
		logic [31:0] sum;
		sum = bse + off;
		md  = addressing_mode_register[{side, num[1:0], 1'b0} +: 2];
		bk  = (md == AM_CIRC_BK1) ? addressing_mode_register[AMR_BK1_LSB +: 5] : addressing_mode_register[AMR_BK0_LSB +: 5];
		msk = (33'h1 << ({1'b0, bk} + 6'h01)) - 33'h1;
		if (num[4:2] == 3'h1 && (md == AM_CIRC_BK0 || md == AM_CIRC_BK1)) begin
			return (bse & ~msk[31:0]) | (sum & msk[31:0]);
		end
		return sum;
	endfunction

	// bus strobes and decode of the command being written
	assign wr       = psel && penable && st_reg.pready && pwrite && (paddr[31:8] == 24'h0);
	assign wr_cmd   = wr && (paddr[7:0] == REG_CMD) && (paddr[31:8] == 24'h0);
	assign cst      = pwdata[CMD_CST_LSB +: 5];
	assign base     = st_reg.src2[31:0];
	assign dp_wr    = (st_reg.dp == DP_WAIT) && (st_reg.cnt == DP_LAT);
	assign clr_inexact_flag = wr && (paddr == {24'h0, REG_FP_ADDER_CONFIG_REGISTER}) && pwdata[FP_ADDER_CONFIG_REGISTER_FLAG_LSB];
	assign fr       = fp_add(st_reg.opa, st_reg.opb, st_reg.rm);

	// integer and address opcode decode, result computed from the current sources
	always_comb begin
		int_ok  = 1'b1;
		is_dp   = 1'b0;
		addr_op = 1'b0;
		scale   = 2'h0;
		off_sc  = 32'h0;
		int_res = 32'h0;
		unique case ({pwdata[CMD_UNIT_LSB +: 2], pwdata[6:0]})
			{UNIT_L, OP_L_ADD}:     int_res = st_reg.src1[31:0] + base;
			{UNIT_S, OP_S_ADD_REG}: int_res = st_reg.src1[31:0] + base;
			{UNIT_S, OP_S_ADD_CST}: int_res = {{27{cst[4]}}, cst} + base;
			{UNIT_D, OP_D_ADD_REG}: int_res = base + st_reg.src1[31:0];
			{UNIT_D, OP_D_ADD_CST}: int_res = base + {27'h0, cst};
			{UNIT_D, OP_AB_REG}, {UNIT_D, OP_AB_CST}: addr_op = 1'b1;
			{UNIT_D, OP_AH_REG}, {UNIT_D, OP_AH_CST}: begin
				addr_op = 1'b1;
				scale   = 2'h1;
			end
			{UNIT_D, OP_AW_REG}, {UNIT_D, OP_AW_CST}: begin
				addr_op = 1'b1;
				scale   = 2'h2;
			end
			{UNIT_D, OP_AD_REG}, {UNIT_D, OP_AD_CST}: begin
				addr_op = 1'b1;
				scale   = 2'h3;
			end
			{UNIT_L, OP_L_DP}: is_dp = 1'b1;
			{UNIT_S, OP_S_DP}: begin
				is_dp  = ENHANCED_CORE;
				int_ok = ENHANCED_CORE;
			end
			default: int_ok = 1'b0;
		endcase
		if (addr_op) begin
			// register forms have bit 1 clear, except the doubleword constant form
			off_sc  = ((pwdata[1] || pwdata[6:0] == OP_AD_CST) ? {27'h0, cst} : st_reg.src1[31:0]) << scale;
			int_res = addr_add(base, off_sc, pwdata[CMD_BASE_LSB +: 5], pwdata[CMD_SIDE_BIT], st_reg.addressing_mode_register);
		end
	end

	// issue only when idle; a false condition is accepted and discarded
	assign int_go = wr_cmd && (st_reg.dp == DP_IDLE) && pwdata[CMD_COND_BIT] && int_ok && !is_dp;
	assign dp_go  = wr_cmd && (st_reg.dp == DP_IDLE) && pwdata[CMD_COND_BIT] && is_dp;

	// next state: apb slave, register writes, integer result, double-add pipeline
	always_comb begin
		st_next        = st_reg;
		// pready rises in the access phase that follows every setup cycle
		st_next.pready  = psel && !penable;
		st_next.pslverr = 1'b0;
		if (psel && !penable) begin
			st_next.prdata = 32'h0;
			if (paddr[31:8] != 24'h0) begin
				st_next.pslverr = 1'b1;
			end else begin
				unique case (paddr[7:0])
					REG_CMD:     st_next.prdata = st_reg.cmd;
					REG_SRC1_LO: st_next.prdata = st_reg.src1[31:0];
					REG_SRC1_HI: st_next.prdata = st_reg.src1[63:32];
					REG_SRC2_LO: st_next.prdata = st_reg.src2[31:0];
					REG_SRC2_HI: st_next.prdata = st_reg.src2[63:32];
					REG_RES_LO:  st_next.prdata = st_reg.res[31:0];
					REG_RES_HI:  st_next.prdata = st_reg.res[63:32];
					REG_STATUS:  st_next.prdata = {29'h0, st_reg.illegal, st_reg.done, st_reg.dp != DP_IDLE};
					REG_AMR:     st_next.prdata = st_reg.addressing_mode_register;
					REG_FP_ADDER_CONFIG_REGISTER:   st_next.prdata = {23'h0, st_reg.fl, st_reg.rm};
					REG_FP_AUXILIARY_CONFIG_REGISTER:   st_next.prdata = st_reg.fp_auxiliary_config_register;
					default:     st_next.pslverr = 1'b1;
				endcase
			end
		end
		if (wr) begin
			unique case (paddr[7:0])
				REG_SRC1_LO: st_next.src1[31:0]  = pwdata;
				REG_SRC1_HI: st_next.src1[63:32] = pwdata;
				REG_SRC2_LO: st_next.src2[31:0]  = pwdata;
				REG_SRC2_HI: st_next.src2[63:32] = pwdata;
				REG_AMR:     st_next.addressing_mode_register         = pwdata;
				REG_FP_AUXILIARY_CONFIG_REGISTER:   st_next.fp_auxiliary_config_register       = pwdata;
				REG_FP_ADDER_CONFIG_REGISTER: begin
					st_next.rm = pwdata[1:0];
					st_next.fl = st_reg.fl & ~fp_flags_s'(pwdata[FP_ADDER_CONFIG_REGISTER_FLAG_LSB +: 7]);
				end
				default: ;
			endcase
		end
		if (wr_cmd) begin
			st_next.cmd     = pwdata;
			st_next.illegal = (st_reg.dp != DP_IDLE) || (pwdata[CMD_COND_BIT] && !int_ok);
		end
		if (int_go) begin
			st_next.res[31:0] = int_res;
			st_next.done      = 1'b1;
		end
		unique case (st_reg.dp)
			DP_IDLE: begin
				if (dp_go) begin
					st_next.dp   = DP_E1;
					st_next.cnt  = 3'h1;
					st_next.done = 1'b0;
				end
			end
			DP_E1: begin
				st_next.opa[31:0] = st_reg.src1[31:0];
				st_next.opb[31:0] = st_reg.src2[31:0];
				st_next.dp        = DP_E2;
				st_next.cnt       = 3'h2;
			end
			DP_E2: begin
				st_next.opa[63:32] = st_reg.src1[63:32];
				st_next.opb[63:32] = st_reg.src2[63:32];
				st_next.dp         = DP_WAIT;
				st_next.cnt        = 3'h3;
			end
			DP_WAIT: begin
				st_next.cnt = st_reg.cnt + 3'h1;
				if (dp_wr) begin
					st_next.res  = fr.val;
					st_next.fl   = st_next.fl | fr.fl;
					st_next.dp   = DP_IDLE;
					st_next.done = 1'b1;
				end
			end
		endcase
	end

	// one register bank for all state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata  = st_reg.prdata;
	assign pready  = st_reg.pready;
	assign pslverr = st_reg.pslverr;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_dp_issue;
		dp_go;
	endsequence
	sequence s_dp_run;
		(st_reg.dp != DP_IDLE) [*6];
	endsequence

	property p_cond_false;
		wr_cmd && !pwdata[CMD_COND_BIT] |=> $stable(st_reg.res);
	endproperty
	a_cond_false: assert property (p_cond_false) else $error("false condition changed result");
	property p_int_next;
		int_go |=> st_reg.res[31:0] == $past(int_res) && st_reg.done;
	endproperty
	a_int_next: assert property (p_int_next) else $error("integer add not written next cycle");
	property p_linear;
		int_go && addr_op && pwdata[CMD_BASE_LSB + 2 +: 3] != 3'h1 |=>
			st_reg.res[31:0] - $past(base) == $past(off_sc);
	endproperty
	a_linear: assert property (p_linear) else $error("linear address add wrong");
	property p_dp_lat;
		s_dp_issue |-> ##7 (st_reg.dp == DP_WAIT && st_reg.cnt == DP_LAT);
	endproperty
	a_dp_lat: assert property (p_dp_lat) else $error("double add result not at seventh edge");
	property p_dp_busy;
		s_dp_issue |=> s_dp_run;
	endproperty
	a_dp_busy: assert property (p_dp_busy) else $error("double add left pipeline early");
	property p_ovf_inexact_flag;
		dp_wr && fr.fl.ovf |=> st_reg.fl.inexact_flag && st_reg.fl.ovf;
	endproperty
	a_ovf_inexact_flag: assert property (p_ovf_inexact_flag) else $error("overflow flags missing");
	property p_invalid_nan;
		dp_wr && fr.fl.invalid_flag |=> st_reg.res == DEFAULT_NAN_RESULT && st_reg.fl.invalid_flag;
	endproperty
	a_invalid_nan: assert property (p_invalid_nan) else $error("invalid without default nan");
	property p_aux_untouched;
		dp_wr && !wr |=> $stable(st_reg.fp_auxiliary_config_register);
	endproperty
	a_aux_untouched: assert property (p_aux_untouched) else $error("auxiliary config changed");
	property p_set_wins;
		dp_wr && fr.fl.inexact_flag && clr_inexact_flag |=> st_reg.fl.inexact_flag;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("inexact lost to clear");
endmodule

// *** adder_pkg.sv ***
// register map, opcodes, field layout and number formats for the add datapath
package adder_pkg;
	// register byte offsets
	localparam logic [7:0] REG_CMD     = 8'h00;
	localparam logic [7:0] REG_SRC1_LO = 8'h04;
	localparam logic [7:0] REG_SRC1_HI = 8'h08;
	localparam logic [7:0] REG_SRC2_LO = 8'h0C;
	localparam logic [7:0] REG_SRC2_HI = 8'h10;
	localparam logic [7:0] REG_RES_LO  = 8'h14;
	localparam logic [7:0] REG_RES_HI  = 8'h18;
	localparam logic [7:0] REG_STATUS  = 8'h1C;
	localparam logic [7:0] REG_AMR     = 8'h20;
	localparam logic [7:0] REG_FP_ADDER_CONFIG_REGISTER   = 8'h24;
	localparam logic [7:0] REG_FP_AUXILIARY_CONFIG_REGISTER   = 8'h28;
	// command, adder config and addressing mode register fields
	localparam int CMD_UNIT_LSB = 7;
	localparam int CMD_COND_BIT = 9;
	localparam int CMD_BASE_LSB = 10;
	localparam int CMD_SIDE_BIT = 15;
	localparam int CMD_CST_LSB  = 16;
	localparam int FP_ADDER_CONFIG_REGISTER_FLAG_LSB = 2;
	localparam int AMR_BK0_LSB  = 16;
	localparam int AMR_BK1_LSB  = 21;
	// functional unit codes
	localparam logic [1:0] UNIT_L = 2'h0;
	localparam logic [1:0] UNIT_S = 2'h1;
	localparam logic [1:0] UNIT_D = 2'h2;
	// operation fields
	localparam logic [6:0] OP_L_ADD     = 7'h03;
	localparam logic [6:0] OP_S_ADD_REG = 7'h07;
	localparam logic [6:0] OP_S_ADD_CST = 7'h06;
	localparam logic [6:0] OP_D_ADD_REG = 7'h10;
	localparam logic [6:0] OP_D_ADD_CST = 7'h12;
	localparam logic [6:0] OP_AB_REG    = 7'h30;
	localparam logic [6:0] OP_AB_CST    = 7'h32;
	localparam logic [6:0] OP_AH_REG    = 7'h34;
	localparam logic [6:0] OP_AH_CST    = 7'h36;
	localparam logic [6:0] OP_AW_REG    = 7'h38;
	localparam logic [6:0] OP_AW_CST    = 7'h3A;
	localparam logic [6:0] OP_AD_REG    = 7'h3C;
	localparam logic [6:0] OP_AD_CST    = 7'h3D;
	localparam logic [6:0] OP_L_DP      = 7'h18;
	localparam logic [6:0] OP_S_DP      = 7'h72;
	// rounding modes
	localparam logic [1:0] RM_NEAREST  = 2'h0;
	localparam logic [1:0] RM_ZERO     = 2'h1;
	localparam logic [1:0] RM_POS_INF  = 2'h2;
	localparam logic [1:0] RM_NEG_INF  = 2'h3;
	// circular modes in the addressing mode register
	localparam logic [1:0] AM_CIRC_BK0 = 2'h1;
	localparam logic [1:0] AM_CIRC_BK1 = 2'h2;
	// double add: issue edge to result edge (six delay slots)
	localparam logic [2:0] DP_LAT      = 3'h7;
	// double-precision constants
	localparam logic [63:0] DEFAULT_NAN_RESULT    = 64'h7FFF_FFFF_FFFF_FFFF;
	localparam logic [62:0] INF_MAG               = 63'h7FF0_0000_0000_0000;
	localparam logic [62:0] LARGEST_FINITE_VALUE  = 63'h7FEF_FFFF_FFFF_FFFF;
	localparam logic [62:0] SMALLEST_NORMAL_VALUE = 63'h0010_0000_0000_0000;

	typedef enum logic [1:0] {DP_IDLE, DP_E1, DP_E2, DP_WAIT} dp_state_e;

	typedef struct packed {
		logic den2;
		logic den1;
		logic unf;
		logic ovf;
		logic infinity_result_flag;
		logic invalid_flag;
		logic inexact_flag;
	} fp_flags_s;

	typedef struct packed {
		logic [63:0] val;
		fp_flags_s   fl;
	} fp_res_s;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic [31:0] cmd;
		logic [63:0] src1;
		logic [63:0] src2;
		logic [63:0] res;
		logic [63:0] opa;
		logic [63:0] opb;
		logic [31:0] addressing_mode_register;
		logic [1:0]  rm;
		fp_flags_s   fl;
		logic [31:0] fp_auxiliary_config_register;
		dp_state_e   dp;
		logic [2:0]  cnt;
		logic        done;
		logic        illegal;
	} state_s;
endpackage

// *** apb_cpu_model.sv ***
// cpu side model that issues register transfers to the add datapath
`timescale 1ns/10ps
module apb_cpu_model (
	// clock
	input  wire logic        pclk,
	// requests toward the datapath
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [31:0] paddr,
	output logic      [31:0] pwdata,
	// answers from the datapath
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// idle bus at time zero
	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 32'h0;
		pwdata  = 32'h0;
	end

	// one transfer, entered just after a rising edge; all held until pready
	task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic err);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= addr;
		pwdata  <= wdata;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdata = prdata;
		err   = pslverr;
		// released data is inverted so a stale value cannot pass for a fresh one
		psel    <= 1'b0;
		penable <= 1'b0;
		pwdata  <= ~wdata;
		@(posedge pclk);
	endtask
endmodule

// *** tb.sv ***
// self-checking bench for the integer, address and double add datapath
`timescale 1ns/10ps
module tb
	import adder_pkg::*;
;
	localparam logic [63:0] ONE = 64'h3FF0_0000_0000_0000;
	localparam logic [63:0] MO  = 64'hBFF0_0000_0000_0000;
	localparam logic [63:0] TWO = 64'h4000_0000_0000_0000;
	localparam logic [63:0] THR = 64'h4008_0000_0000_0000;
	localparam logic [63:0] SN  = 64'h7FF0_0000_0000_0001;
	localparam logic [63:0] QN  = 64'h7FF8_0000_0000_0000;
	localparam logic [63:0] UA  = 64'h0018_0000_0000_0000;
	localparam logic [63:0] NUA = 64'h8018_0000_0000_0000;
	localparam logic [63:0] TI  = 64'h3C30_0000_0000_0000;
	localparam logic [63:0] NZ  = 64'h8000_0000_0000_0000;
	localparam logic [63:0] PI  = {1'b0, INF_MAG};
	localparam logic [63:0] NI  = {1'b1, INF_MAG};
	localparam logic [63:0] LF  = {1'b0, LARGEST_FINITE_VALUE};
	localparam logic [63:0] NL  = {1'b1, LARGEST_FINITE_VALUE};
	localparam logic [63:0] SF  = {1'b0, SMALLEST_NORMAL_VALUE};
	localparam logic [63:0] NS  = {1'b1, SMALLEST_NORMAL_VALUE};
	localparam logic [31:0] CI  = 32'h0002_0001;

	typedef struct packed {
		logic [31:0] cmd;
		logic [31:0] s1;
		logic [31:0] s2;
		logic [31:0] addressing_mode_register;
		logic [31:0] res;
	} int_row_s;
	typedef struct packed {
		logic [6:0]  op;
		logic [1:0]  rm;
		logic [63:0] a;
		logic [63:0] b;
		logic [63:0] val;
		logic [6:0]  fl;
	} dp_row_s;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] rd;
	logic        er;
	int          fails;
	int          n_tests;
	int_row_s    ir [18];
	dp_row_s     dr [26];

	add_and_scaled_address_adder #(.ENHANCED_CORE(1'b1)) u_add_and_scaled_address_adder (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	apb_cpu_model u_apb_cpu_model (
		.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// 50 MHz clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// compare and count
	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_apb_cpu_model.xfer(1'b1, {24'h0, a}, d, rd, er);
	endtask
	task automatic rdr(input logic [7:0] a);
		u_apb_cpu_model.xfer(1'b0, {24'h0, a}, 32'h0, rd, er);
	endtask
	// poll status until the double add unit is free, bounded
	task automatic wait_idle;
		int k;
		k = 0;
		rdr(REG_STATUS);
		while (rd[0] !== 1'b0 && k < 10) begin
			rdr(REG_STATUS);
			k++;
		end
		check("idle wait", {63'h0, rd[0]}, 64'h0);
	endtask
	function automatic logic [31:0] cmdf(input logic [6:0] op, input logic [1:0] u, input logic [4:0] c,
		input logic [4:0] b);
		return {11'h0, c, 1'b0, b, 1'b1, u, op};
	endfunction
	// one double add: mode and flag clear, operands, issue, result and flags
	task automatic dp_run(input dp_row_s r);
		logic [31:0] lo;
		wr(REG_FP_ADDER_CONFIG_REGISTER, {23'h0, 7'h7F, r.rm});
		wr(REG_SRC1_LO, r.a[31:0]);
		wr(REG_SRC1_HI, r.a[63:32]);
		wr(REG_SRC2_LO, r.b[31:0]);
		wr(REG_SRC2_HI, r.b[63:32]);
		wr(REG_CMD, cmdf(r.op, (r.op == OP_S_DP) ? UNIT_S : UNIT_L, 5'h00, 5'h00));
		rdr(REG_STATUS);
		check("dp busy", {63'h0, rd[0]}, 64'h1);
		wait_idle();
		rdr(REG_RES_LO);
		lo = rd;
		rdr(REG_RES_HI);
		check("dp result", {rd, lo}, r.val);
		rdr(REG_FP_ADDER_CONFIG_REGISTER);
		check("dp flags", {32'h0, rd}, {32'h0, 23'h0, r.fl, r.rm});
	endtask
	task automatic end_sim;
		$display("counts: %0d checks, %0d mismatches", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// watchdog, far beyond the expected run length
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		$display("watchdog expired");
		end_sim();
	end

	// main sequence
	initial begin
		presetn = 1'b0;
		fails = 0;
		n_tests = 0;
		ir = '{
			'{cmdf(OP_L_ADD, UNIT_L, 5'h00, 5'h00), 32'h5, 32'h7, 32'h0, 32'hC},
			'{cmdf(OP_S_ADD_REG, UNIT_S, 5'h00, 5'h00), 32'hFFFF_FFFF, 32'h3, 32'h0, 32'h2},
			'{cmdf(OP_S_ADD_CST, UNIT_S, 5'h1F, 5'h00), 32'h0, 32'hA, 32'h0, 32'h9},
			'{cmdf(OP_S_ADD_REG, UNIT_S, 5'h00, 5'h00) & 32'hFFFF_FDFF, 32'h1, 32'h64, 32'h0, 32'h9},
			'{cmdf(OP_D_ADD_REG, UNIT_D, 5'h00, 5'h00), 32'h20, 32'h1000, 32'h0, 32'h1020},
			'{cmdf(OP_D_ADD_CST, UNIT_D, 5'h1F, 5'h00), 32'h0, 32'h1000, 32'h0, 32'h101F},
			'{cmdf(OP_AB_REG, UNIT_D, 5'h00, 5'h00), 32'hB, 32'h100, 32'h0, 32'h10B},
			'{cmdf(OP_AB_CST, UNIT_D, 5'h1F, 5'h00), 32'h0, 32'h100, 32'h0, 32'h11F},
			'{cmdf(OP_AH_REG, UNIT_D, 5'h00, 5'h00), 32'h42, 32'h20_1000, 32'h0, 32'h20_1084},
			'{cmdf(OP_AH_CST, UNIT_D, 5'h03, 5'h00), 32'h0, 32'h100, 32'h0, 32'h106},
			'{cmdf(OP_AW_REG, UNIT_D, 5'h00, 5'h00), 32'h42, 32'h20_1000, 32'h0, 32'h20_1108},
			'{cmdf(OP_AW_CST, UNIT_D, 5'h02, 5'h00), 32'h0, 32'h1000, 32'h0, 32'h1008},
			'{cmdf(OP_AD_REG, UNIT_D, 5'h00, 5'h00), 32'h2, 32'h1234, 32'h0, 32'h1244},
			'{cmdf(OP_AD_CST, UNIT_D, 5'h01, 5'h00), 32'h0, 32'h10, 32'h0, 32'h18},
			'{cmdf(OP_AB_REG, UNIT_D, 5'h00, 5'h04), 32'hB, 32'h100, CI, 32'h103},
			'{cmdf(OP_AH_REG, UNIT_D, 5'h00, 5'h04), 32'hB, 32'h100, CI, 32'h106},
			'{cmdf(OP_AW_CST, UNIT_D, 5'h02, 5'h04), 32'h0, 32'h2_0000, CI, 32'h2_0000},
			'{cmdf(OP_AB_REG, UNIT_D, 5'h00, 5'h03), 32'hB, 32'h100, CI, 32'h10B}};
		dr = '{
			'{OP_L_DP, RM_NEAREST, ONE, TWO, THR, 7'h00}, '{OP_S_DP, RM_NEAREST, ONE, TWO, THR, 7'h00},
			'{OP_L_DP, RM_NEAREST, SN, ONE, DEFAULT_NAN_RESULT, 7'h02},
			'{OP_L_DP, RM_NEAREST, ONE, QN, DEFAULT_NAN_RESULT, 7'h00},
			'{OP_L_DP, RM_NEAREST, PI, NI, DEFAULT_NAN_RESULT, 7'h02},
			'{OP_L_DP, RM_NEAREST, NI, ONE, NI, 7'h04},
			'{OP_L_DP, RM_NEAREST, LF, LF, PI, 7'h09}, '{OP_L_DP, RM_ZERO, LF, LF, LF, 7'h09},
			'{OP_L_DP, RM_POS_INF, LF, LF, PI, 7'h09}, '{OP_L_DP, RM_NEG_INF, LF, LF, LF, 7'h09},
			'{OP_L_DP, RM_NEAREST, NL, NL, NI, 7'h09}, '{OP_L_DP, RM_ZERO, NL, NL, NL, 7'h09},
			'{OP_L_DP, RM_POS_INF, NL, NL, NL, 7'h09}, '{OP_L_DP, RM_NEG_INF, NL, NL, NI, 7'h09},
			'{OP_L_DP, RM_NEAREST, UA, NS, 64'h0, 7'h11}, '{OP_L_DP, RM_ZERO, UA, NS, 64'h0, 7'h11},
			'{OP_L_DP, RM_POS_INF, UA, NS, SF, 7'h11}, '{OP_L_DP, RM_NEG_INF, UA, NS, 64'h0, 7'h11},
			'{OP_L_DP, RM_NEG_INF, NUA, SF, NS, 7'h11}, '{OP_L_DP, RM_POS_INF, NUA, SF, NZ, 7'h11},
			'{OP_L_DP, RM_NEAREST, ONE, MO, 64'h0, 7'h00}, '{OP_L_DP, RM_NEG_INF, ONE, MO, NZ, 7'h00},
			'{OP_L_DP, RM_NEAREST, 64'h1, ONE, ONE, 7'h21},
			'{OP_L_DP, RM_POS_INF, 64'h1, ONE, ONE, 7'h21},
			'{OP_L_DP, RM_NEAREST, ONE, TI, ONE, 7'h01},
			'{OP_L_DP, RM_POS_INF, ONE, TI, 64'h3FF0_0000_0000_0001, 7'h01}};
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// every register is clear after reset
		for (int a = 0; a <= 40; a += 4) begin
			rdr(a[7:0]);
			check("reset value", {32'h0, rd}, 64'h0);
		end
		$display("test reset values done");
		// integer and scaled address adds, each read back by the next transfer
		foreach (ir[i]) begin
			wr(REG_AMR, ir[i].addressing_mode_register);
			wr(REG_SRC1_LO, ir[i].s1);
			wr(REG_SRC2_LO, ir[i].s2);
			wr(REG_CMD, ir[i].cmd);
			rdr(REG_RES_LO);
			check("int result", {32'h0, rd}, {32'h0, ir[i].res});
		end
		$display("test integer and address adds done");
		// double adds, auxiliary register must stay untouched
		wr(REG_FP_AUXILIARY_CONFIG_REGISTER, 32'h0000_A5A5);
		foreach (dr[i]) begin
			dp_run(dr[i]);
		end
		rdr(REG_FP_AUXILIARY_CONFIG_REGISTER);
		check("aux config", {32'h0, rd}, 64'h0000_A5A5);
		$display("test double adds done");
		// awkward: unmapped read, unknown opfield, command while busy
		rdr(8'h2C);
		check("unmapped err", {63'h0, er}, 64'h1);
		check("unmapped data", {32'h0, rd}, 64'h0);
		// upper address bits set: refused, the mode register keeps its value
		u_apb_cpu_model.xfer(1'b1, 32'h0000_0120, 32'hFFFF_FFFF, rd, er);
		check("high addr err", {63'h0, er}, 64'h1);
		rdr(REG_AMR);
		check("high addr ignored", {32'h0, rd}, {32'h0, CI});
		wr(REG_CMD, cmdf(7'h7F, UNIT_L, 5'h00, 5'h00));
		rdr(REG_STATUS);
		check("illegal opfield", {63'h0, rd[2]}, 64'h1);
		wr(REG_FP_ADDER_CONFIG_REGISTER, 32'h0000_01FC);
		wr(REG_CMD, cmdf(OP_L_DP, UNIT_L, 5'h00, 5'h00));
		wr(REG_CMD, cmdf(OP_L_ADD, UNIT_L, 5'h00, 5'h00));
		rdr(REG_STATUS);
		check("busy refusal", {62'h0, rd[2], rd[0]}, 64'h3);
		wait_idle();
		rdr(REG_STATUS);
		check("idle after dp", {63'h0, rd[0]}, 64'h0);
		// inexact clear lands on the result edge (issue + 7): the set must win
		wr(REG_CMD, cmdf(OP_L_DP, UNIT_L, 5'h00, 5'h00));
		repeat (4) @(posedge pclk);
		wr(REG_FP_ADDER_CONFIG_REGISTER, 32'h0000_0004);
		wait_idle();
		rdr(REG_FP_ADDER_CONFIG_REGISTER);
		check("set wins", {32'h0, rd}, 64'h4);
		$display("test refusals done");
		end_sim();
	end
endmodule
